// ===== bit_map.svh
// Purpose: Register offsets, field positions and reset values of the
//          interval timer.
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef BIT_MAP_SVH
`define BIT_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define BIT_CTRL_OFFSET   8'hF2
`define BIT_CTRL_INDEX    8'hF2
`define BIT_CTRL_ADDR     10'h3C8
`define BIT_COUNT_ADDR    10'h3CC

// ---------------------------------------------------------------------------
// Control register fields and reset value
// ---------------------------------------------------------------------------
`define BIT_PRESCALE_LSB  0
`define BIT_PRESCALE_MSB  2
`define BIT_CLEAR_POS     3
`define BIT_WDOG_POS      4
`define BIT_CTRL_RESET    8'h17

// ---------------------------------------------------------------------------
// Prescaler
// ---------------------------------------------------------------------------
`define BIT_PRESCALE_BASE 3
`define BIT_DIV_WIDTH     10

`endif

// ===== bit_pkg.sv
// Purpose: Types shared by the interval timer.
// Assumes: Nothing beyond the map header.
// Notes:   Constants live in bit_map.svh.
package bit_pkg;

  // AXI write response codes.
  typedef enum logic [1:0] {
    BIT_RESP_OKAY   = 2'h0,
    BIT_RESP_SLVERR = 2'h2
  } bit_resp_t;

endpackage : bit_pkg

// ===== bit_timer.sv
// Purpose: Free-running 8-bit interval timer with prescaler and an
//          AXI4-Lite register slave.
// Assumes: aclk is the oscillator clock; one machine cycle is one aclk.
// Notes:   Overflow and watchdog tick are one-cycle pulses. The control
//          register sits at word index 0xF2 (byte 0x3C8) and the read-only
//          count register at byte 0x3CC. Only the low byte lane of a write
//          reaches the control fields; a write to the count register is
//          accepted and ignored, and any other value of address bits 9:0 answers SLVERR.
//          The watchdog compare itself lives outside this block.
// How it works
// R1: Eight-bit counter runs freely, cannot be stopped.
// R2: Counter advances only on prescaler count pulses.
// R3: Wrap from FF to 00 raises interrupt.
// R4: Writing clear bit zeroes counter, counting resumes.
// R5: Clear bit self-clears one machine cycle later.
// R6: Watchdog select chooses watchdog or plain timer.
// R7: Three-bit prescale selects divide 8 to 1024.
// R8: Overflow clocks the watchdog counter.
// R9: Software reads the current count value.
// R10: Watchdog select reads one after reset.
// R11: Interrupt and tick are single-cycle pulses.
`timescale 1ns/1ps
`include "bit_map.svh"

module bit_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  interval_irq,
  output logic                  watchdog_tick,
  output logic                  watchdog_select_bit
);
  import bit_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [`BIT_DIV_WIDTH-1:0] div;
    logic [CNT_W-1:0]          count;
    logic [2:0]                prescale_select;
    logic                      count_clear_bit;
    logic                      watchdog_select_bit;
    logic                      irq;
    logic                      tick;
    logic                      awready;
    logic                      wready;
    logic                      aw_held;
    logic [31:0]               aw_addr;
    logic                      w_held;
    logic [31:0]               w_data;
    logic                      w_strb0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } bit_state_t;

  bit_state_t state_reg;
  bit_state_t state_next;

  logic [`BIT_DIV_WIDTH-1:0] div_mask;
  logic                      count_pulse;
  logic [9:0]                wr_word;
  logic [9:0]                rd_word;
  logic                      wr_go;

  // Divider tap: the mask covers 2^(code+3) cycles so each step doubles.
  // Tapping one free-running divider, instead of a reload counter per
  // code, costs nothing extra but means a code change mid-period can
  // shorten or stretch that one period; only a clear restarts it cleanly.
  always_comb begin
    div_mask = `BIT_DIV_WIDTH'((11'h008 << state_reg.prescale_select) - 11'h001);
  end

  // One count pulse when all masked divider bits are ones.
  // The pulse lasts one cycle because the divider moves on every edge.
  assign count_pulse = ((state_reg.div & div_mask) == div_mask); // R2 R7
  assign wr_word     = state_reg.aw_addr[9:0];
  assign rd_word     = s_axi_araddr[9:0];
  assign wr_go       = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Timer and bus slave share one process so the clear write and the count
  // update cannot disagree about which wins.
  always_comb begin
    state_next      = state_reg;
    state_next.irq  = 1'b0;
    state_next.tick = 1'b0;

    // The divider never stops; software has no enable for it.
    state_next.div = state_reg.div + `BIT_DIV_WIDTH'(1); // R1

    // Counter: clear has priority, then count pulses. The clear also
    // zeroes the divider so the first period after a clear is a full one;
    // a wrap that coincides with a clear is dropped, not reported.
    state_next.count_clear_bit = 1'b0; // R5
    if (state_reg.count_clear_bit) begin
      state_next.count = '0; // R4
      state_next.div   = '0;
    end else if (count_pulse) begin
      state_next.count = state_reg.count + CNT_W'(1); // R1 R2
      if (&state_reg.count) begin
        state_next.irq  = 1'b1; // R3 R11
        state_next.tick = 1'b1; // R8 R11
      end
    end

    // Write address and data are taken independently, in either order.
    // Each half parks in its own holding slot, so a master that offers
    // data before the address is served just as well as the reverse.
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held  = 1'b1;
      state_next.w_data  = s_axi_wdata;
      state_next.w_strb0 = s_axi_wstrb[0];
    end

    // Commit a write once both halves are here. Only byte lane 0 carries
    // the control fields, so a write with that strobe low changes nothing
    // but still gets an OKAY answer.
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = BIT_RESP_OKAY;
      if (wr_word == `BIT_CTRL_ADDR) begin
        if (state_reg.w_strb0) begin
          state_next.prescale_select =
            state_reg.w_data[`BIT_PRESCALE_MSB:`BIT_PRESCALE_LSB]; // R7
          state_next.count_clear_bit =
            state_reg.w_data[`BIT_CLEAR_POS]; // R4
          state_next.watchdog_select_bit =
            state_reg.w_data[`BIT_WDOG_POS]; // R6
        end
      end else if (wr_word != `BIT_COUNT_ADDR) begin
        state_next.bresp = BIT_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Read: one cycle accept, data in the same cycle. The count is sampled at
    // the accept edge, so a read racing a count pulse shows the old value.
    state_next.arready = 1'b0;
    if (s_axi_arvalid && !state_reg.arready && !state_reg.rvalid) begin
      state_next.arready = 1'b1;
      state_next.rvalid  = 1'b1;
      state_next.rresp   = BIT_RESP_OKAY;
      state_next.rdata   = '0;
      if (rd_word == `BIT_CTRL_ADDR) begin
        state_next.rdata[`BIT_WDOG_POS]  = state_reg.watchdog_select_bit;
        state_next.rdata[`BIT_CLEAR_POS] = state_reg.count_clear_bit;
        state_next.rdata[`BIT_PRESCALE_MSB:`BIT_PRESCALE_LSB] =
          state_reg.prescale_select;
      end else if (rd_word == `BIT_COUNT_ADDR) begin
        state_next.rdata[CNT_W-1:0] = state_reg.count; // R9
      end else begin
        state_next.rresp = BIT_RESP_SLVERR;
      end
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // Ready flags are registered copies of the free half slots, so the
    // ports come straight from flip-flops with no gate in front.
    state_next.awready = !state_next.aw_held;
    state_next.wready  = !state_next.w_held;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Reset value of the control register puts the watchdog in charge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg                     <= '0;
      state_reg.awready             <= 1'b1;
      state_reg.wready              <= 1'b1;
      state_reg.prescale_select     <= 3'(`BIT_CTRL_RESET); // R7
      state_reg.watchdog_select_bit <=
        1'(`BIT_CTRL_RESET >> `BIT_WDOG_POS); // R10
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs all come straight from flip-flops.
  assign s_axi_awready       = state_reg.awready;
  assign s_axi_wready        = state_reg.wready;
  assign s_axi_bvalid        = state_reg.bvalid;
  assign s_axi_bresp         = state_reg.bresp;
  assign s_axi_arready       = state_reg.arready;
  assign s_axi_rvalid        = state_reg.rvalid;
  assign s_axi_rdata         = state_reg.rdata;
  assign s_axi_rresp         = state_reg.rresp;
  assign interval_irq        = state_reg.irq;
  assign watchdog_tick       = state_reg.tick;
  assign watchdog_select_bit = state_reg.watchdog_select_bit; // R6

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // All checks run on aclk and are silenced while reset is held, but the
  // $past values seen in the first cycle after reset come from reset cycles.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------------------
  // Timer checks
  // ---------------------------------------------------------------------------

  wrap_irq_a: assert property ( // R3
    (count_pulse && !state_reg.count_clear_bit && &state_reg.count)
      |=> interval_irq && state_reg.count == '0)
    else $error("Wrap did not raise interrupt.");
  irq_pulse_a: assert property (interval_irq |=> !interval_irq) // R11
    else $error("Interrupt longer than one cycle.");
  tick_match_a: assert property ( // R8
    watchdog_tick |-> interval_irq && state_reg.count == '0
      && $past(&state_reg.count))
    else $error("Watchdog tick not tied to a wrap.");
  clear_self_a: assert property ( // R5
    state_reg.count_clear_bit |=> !state_reg.count_clear_bit)
    else $error("Clear bit did not self-clear.");
  clear_zero_a: assert property ( // R4
    state_reg.count_clear_bit |=> state_reg.count == '0)
    else $error("Clear did not zero counter.");
  count_hold_a: assert property ( // R2
    (!count_pulse && !state_reg.count_clear_bit)
      |=> $stable(state_reg.count))
    else $error("Counter moved without pulse.");
  count_step_a: assert property ( // R1
    (count_pulse && !state_reg.count_clear_bit)
      |=> state_reg.count == CNT_W'($past(state_reg.count) + 1))
    else $error("Counter did not advance.");
  div8_rate_a: assert property ( // R7
    (state_reg.prescale_select == 3'h0 && state_reg.div[2:0] == 3'h0
      && !state_reg.count_clear_bit)
      ##1 (state_reg.prescale_select == 3'h0
      && !state_reg.count_clear_bit) [*7] |-> count_pulse)
    else $error("Divide by 8 pulse missing.");
  wdog_write_a: assert property ( // R6
    (wr_go && wr_word == `BIT_CTRL_ADDR && state_reg.w_strb0)
      |=> watchdog_select_bit == $past(state_reg.w_data[`BIT_WDOG_POS]))
    else $error("Watchdog select not written.");
  read_count_a: assert property ( // R9
    (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      && rd_word == `BIT_COUNT_ADDR)
      |=> s_axi_rvalid && s_axi_rdata[CNT_W-1:0] == $past(state_reg.count))
    else $error("Count read wrong.");
  ctrl_read_a: assert property ( // R6 R7
    (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      && rd_word == `BIT_CTRL_ADDR)
      |=> s_axi_rdata[`BIT_WDOG_POS] == $past(state_reg.watchdog_select_bit)
        && s_axi_rdata[`BIT_PRESCALE_MSB:`BIT_PRESCALE_LSB]
          == $past(state_reg.prescale_select))
    else $error("Control read wrong.");

  // A wrap is only reported for a real count pulse, never by a clear.
  irq_source_a: assert property ( // R3
    interval_irq |-> $past(count_pulse && !state_reg.count_clear_bit))
    else $error("Interrupt without a count pulse.");
  // The divider runs on every edge; only a clear may restart it.
  div_run_a: assert property ( // R1
    !state_reg.count_clear_bit
      |=> state_reg.div == `BIT_DIV_WIDTH'($past(state_reg.div) + 1))
    else $error("Prescaler divider stalled.");
  div_clear_a: assert property ( // R4
    state_reg.count_clear_bit |=> state_reg.div == '0)
    else $error("Clear did not restart prescaler.");
  clear_write_a: assert property ( // R4
    (wr_go && wr_word == `BIT_CTRL_ADDR && state_reg.w_strb0
      && state_reg.w_data[`BIT_CLEAR_POS])
      |=> state_reg.count_clear_bit)
    else $error("Clear write not taken.");
  prescale_write_a: assert property ( // R7
    (wr_go && wr_word == `BIT_CTRL_ADDR && state_reg.w_strb0)
      |=> state_reg.prescale_select
        == $past(state_reg.w_data[`BIT_PRESCALE_MSB:`BIT_PRESCALE_LSB]))
    else $error("Prescale select not written.");
  wsel_hold_a: assert property ( // R6
    !(wr_go && wr_word == `BIT_CTRL_ADDR && state_reg.w_strb0)
      |=> $stable(watchdog_select_bit))
    else $error("Watchdog select changed unwritten.");

  // ---------------------------------------------------------------------------
  // Bus slave checks
  // ---------------------------------------------------------------------------
  // Ready ports must mirror the holding slots one for one.
  aw_ready_a: assert property (s_axi_awready == !state_reg.aw_held)
    else $error("Write address ready out of step.");
  w_ready_a: assert property (s_axi_wready == !state_reg.w_held)
    else $error("Write data ready out of step.");
  // Each read is accepted once, in a single cycle.
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("Read accept longer than one cycle.");
  rd_unmapped_a: assert property (
    (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      && rd_word != `BIT_CTRL_ADDR && rd_word != `BIT_COUNT_ADDR)
      |=> s_axi_rresp == BIT_RESP_SLVERR)
    else $error("Unmapped read not refused.");
  wr_ok_a: assert property (
    (wr_go && wr_word == `BIT_CTRL_ADDR)
      |=> s_axi_bvalid && s_axi_bresp == BIT_RESP_OKAY)
    else $error("Control write not answered OKAY.");
  wr_unmapped_a: assert property (
    (wr_go && wr_word != `BIT_CTRL_ADDR && wr_word != `BIT_COUNT_ADDR)
      |=> s_axi_bvalid && s_axi_bresp == BIT_RESP_SLVERR)
    else $error("Unmapped write not refused.");

  // ---------------------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------------------
  // Main scenarios: a wrap, a clear, one read and one write handshake.
  wrap_c:  cover property (interval_irq);
  clear_c: cover property (state_reg.count_clear_bit);
  read_c:  cover property (s_axi_rvalid && s_axi_rready);
  write_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule : bit_timer

// ===== bit_watchdog_model.sv
// Purpose: Far-side model, watchdog 7-bit counter and interrupt tally.
// Assumes: Tick and request are one-cycle pulses on aclk.
// Notes:   The watchdog compare and reset logic is not modelled.
`timescale 1ns/1ps
module bit_watchdog_model (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   interval_irq,
  input  wire logic   watchdog_tick,
  output logic [6:0]  wdog_count,
  output logic [15:0] irq_count
);
  typedef struct packed {
    logic [6:0]  wdog;
    logic [15:0] irqs;
  } bit_wdm_state_t;
  bit_wdm_state_t state_reg;
  bit_wdm_state_t state_next;
  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  // The watchdog counter only moves on a tick, so a lost tick shows up.
  always_comb begin
    state_next = state_reg;
    if (watchdog_tick) state_next.wdog = state_reg.wdog + 7'h01;
    if (interval_irq) state_next.irqs = state_reg.irqs + 16'h0001;
  end
  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) state_reg <= '0;
    else state_reg <= state_next;
  end
  assign wdog_count = state_reg.wdog;
  assign irq_count  = state_reg.irqs;
endmodule : bit_watchdog_model

// ===== test_basic_interval_timer.sv
// Purpose: Self-checking bench for the interval timer.
// Assumes: Every bus answer comes within 200 cycles.
// Notes:   Wrap periods are timed for codes 0 to 2 only, to keep the run
//          short; every code is rate-checked through the count register.
`timescale 1ns/1ps
`include "bit_map.svh"
module test_basic_interval_timer;
  import bit_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, tick, wsel;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [6:0]  wdog_count;
  logic [15:0] irq_count;
  int          fails, checked, n;
  bit_timer u_bit_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .interval_irq(irq),
    .watchdog_tick(tick), .watchdog_select_bit(wsel));
  bit_watchdog_model u_bit_watchdog_model (.aclk(aclk), .aresetn(aresetn),
    .interval_irq(irq), .watchdog_tick(tick), .wdog_count(wdog_count),
    .irq_count(irq_count));
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Range compare; lo equal to hi makes it exact.
  task chk(input string s, input logic [31:0] lo, hi, got);
    checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fails++;
      $display("CHECK FAILED %s expected %0h..%0h seen %0h", s, lo, hi, got);
    end
  endtask : chk
  task lost(input int k);
    if (k >= 200) begin fails++; results; end
  endtask : lost
  // Both write halves offered together, each dropped when taken.
  task wr(input logic [31:0] a, dv, output logic [1:0] rs);
    int k;
    // Let an edge pass so nothing just lowered is raised in one time step.
    @(posedge aclk);
    awaddr <= a; wdata <= dv; awvalid <= 1; wvalid <= 1; bready <= 1; k = 0;
    do begin
      @(posedge aclk); k++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && k < 200);
    lost(k); bready <= 0; rs = bresp;
  endtask : wr
  task rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1; k = 0;
    do begin
      @(posedge aclk); k++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && k < 200);
    lost(k); rready <= 0; dv = rdata; rs = rresp;
  endtask : rd
  // Waits for a wrap pulse and checks its shape; cycles land in k.
  task wirq(output int k);
    k = 0;
    do begin @(posedge aclk); k++; end while (irq !== 1'b1 && k < 20000);
    if (k >= 20000) begin fails++; results; end
    chk("tick", 1, 1, {31'h0, tick});
    @(posedge aclk);
    chk("irq pulse", 0, 0, {31'h0, irq});
  endtask : wirq
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_reset;
    rd(`BIT_CTRL_ADDR, d, r); chk("ctrl reset", 32'h17, 32'h17, d);
    chk("select", 1, 1, {31'h0, wsel});
    rd(32'h0000_0100, d, r); chk("rd unmapped", 2, 2, {30'h0, r});
    wr(32'h0000_0100, 32'h0, r); chk("wr unmapped", 2, 2, {30'h0, r});
  endtask : t_reset
  // Period between wraps is 256 count pulses of 2^(code+3) cycles.
  task t_period(input int c);
    wr(`BIT_CTRL_ADDR, 32'h10 | c, r);
    rd(`BIT_CTRL_ADDR, d, r); chk("ctrl code", 32'h10|c, 32'h10|c, d);
    wirq(n); wirq(n);
    chk("period", 2048 << c, 2048 << c, n + 1);
  endtask : t_period
  task t_clear;
    wirq(n); repeat (400) @(posedge aclk);
    // Code 2 is left from the period test: one pulse per 32 cycles, and
    // 403 cycles pass from the wrap to the read accept.
    rd(`BIT_COUNT_ADDR, d, r); chk("count", 12, 12, d);
    wr(`BIT_CTRL_ADDR, 32'h18, r);
    rd(`BIT_CTRL_ADDR, d, r); chk("clear bit", 32'h10, 32'h10, d);
    rd(`BIT_COUNT_ADDR, d, r); chk("cleared", 0, 1, d);
    wirq(n); chk("after clear", 2030, 2048, n);
  endtask : t_clear
  task t_select;
    wr(`BIT_CTRL_ADDR, 32'h00, r); @(posedge aclk);
    chk("select off", 0, 0, {31'h0, wsel});
    wr(`BIT_CTRL_ADDR, 32'h17, r); @(posedge aclk);
    chk("select on", 1, 1, {31'h0, wsel});
    chk("wdog", {25'h0, irq_count[6:0]}, {25'h0, irq_count[6:0]},
        {25'h0, wdog_count});
    chk("irqs", 1, 32'h0000_FFFF, {16'h0, irq_count});
  endtask : t_select
  // A clear restarts the divider, so after three periods and one cycle of
  // read accept the count reads exactly three.
  task t_rate(input int c);
    wr(`BIT_CTRL_ADDR, 32'h18 | c, r);
    repeat (3 << (c + 3)) @(posedge aclk);
    rd(`BIT_COUNT_ADDR, d, r); chk("rate count", 3, 3, d);
  endtask : t_rate
  // Clock at 200 MHz.
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  // Main sequence.
  initial begin
    fails = 0; checked = 0; aresetn = 0; awvalid = 0; wvalid = 0;
    bready = 0; arvalid = 0; rready = 0; awaddr = 0; wdata = 0; araddr = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    for (int c = 0; c < 3; c++) t_period(c);
    t_clear;
    t_select;
    for (int c = 0; c < 8; c++) t_rate(c);
    // A mid-run reset must bring back the control reset value.
    wr(`BIT_CTRL_ADDR, 32'h02, r);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    results;
  end
endmodule : test_basic_interval_timer
